// file: rtl/flash_erase_regs.svh
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

// register byte offsets
`define OFS_FLASH_CONTROL 5'h00
`define OFS_PROTECT_BYTE 5'h04
`define OFS_LATCH_ADDR 5'h08
`define OFS_ERASE_RANGE 5'h0C
`define OFS_STATUS 5'h10
`define OFS_SECOND_CONFIG 5'h14

// flash_control_reg field positions
`define FCR_PROGRAM_SELECT 0
`define FCR_ERASE_SELECT 1
`define FCR_MARGIN 2
`define FCR_HIGH_VOLTAGE_ON 3
`define FCR_BLOCK_SIZE_SEL0 4
`define FCR_BLOCK_SIZE_SEL1 5
`define FCR_PUMP_DIV_SEL0 6
`define FCR_PUMP_DIV_SEL1 7
`define FCR_RESET 8'h00

// second_config_reg field position and reset
`define CFG2_PUMP_REGULATOR_ENABLE 0
`define CFG2_RESET 1'b0

// protect byte field positions
`define PROT_UPPER_BIT 3
`define PROT_LOW_MSB 2

// address map of the array
`define USER_LO 16'hB000
`define USER_HI 16'hFDFF
`define VEC_LO 16'hFFDC
`define VEC_HI 16'hFFFF
`define QUARTER_LO 16'hC000
`define FIFTH_HI 16'hBFFF
`define ADDR_BIT_FIFTH 14
`define ROW8_LSB 9
`define ROW1_LSB 6

// pump clock divide ratios minus one
`define PUMP_DIV1_LAST 2'h0
`define PUMP_DIV2_LAST 2'h1
`define PUMP_DIV4_LAST 2'h3

`endif

// file: rtl/flash_erase_pkg.sv
package flash_erase_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_CONFIGURED,
    SEQ_PROTECT_READ,
    SEQ_ADDR_LATCHED
  } seq_type;

  typedef struct packed {
    logic pump_div_sel1;
    logic pump_div_sel0;
    logic block_size_sel1;
    logic block_size_sel0;
    logic high_voltage_on;
    logic margin;
    logic erase_select;
    logic program_select;
  } ctrl_type;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
    logic vectors;
  } range_type;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    ctrl_type ctrl;
    logic pump_regulator_enable;
    seq_type seq;
    logic [7:0] protect;
    logic [15:0] latched_addr;
    range_type range;
    logic protect_hit;
    logic [1:0] div_cnt;
    logic pump_tick;
  } state_type;

endpackage : flash_erase_pkg

// file: rtl/flash_block_erase_control.sv
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "flash_erase_regs.svh"
// Notes on behaviour
// - in erase mode the write address is latched and selects the erased block.
// - erased block reads back as all zeros.
// - size bits 00: whole array B000-FDFF plus vectors FFDC-FFFF.
// - size bits 01, bit 14 high: C000-FDFF plus vectors.
// - size bits 01, bit 14 low: B000-BFFF only.
// - size bits 10: 512-byte block chosen by address bits 15 to 9.
// - size bits 11: 64-byte row chosen by address bits 15 to 6.
// - high voltage settable only with a select bit and correct sequence.
// - erase and program select can never both be one.
// - range touching a protected block clears erase select.
// - pump clock divides bus clock by 1, 2, 2 or 4.
module flash_block_erase_control
  import flash_erase_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // protect byte as stored in the array
  input wire logic [7:0] protect_byte_i,
  // array and charge pump control
  output logic high_voltage_on_o,
  output logic erase_select_o,
  output logic program_select_o,
  output logic margin_o,
  output logic pump_regulator_enable_o,
  output logic pump_tick_o,
  output logic [15:0] erase_lo_o,
  output logic [15:0] erase_hi_o,
  output logic erase_vectors_o
);

  state_type st_r;
  state_type st_nxt;

  // an address counts as flash only inside user memory or the vector table
  function automatic logic is_flash(input logic [15:0] a);
    is_flash = (a >= `USER_LO && a <= `USER_HI) || (a >= `VEC_LO);
  endfunction : is_flash

  function automatic range_type decode_range(input logic [15:0] a, input logic [1:0] blk);
    range_type r;
    r = '0;
    unique case (blk)
      2'b00: begin
        r.lo = `USER_LO;
        r.hi = `USER_HI;
        r.vectors = 1'b1;
      end
      2'b01: begin
        if (a[`ADDR_BIT_FIFTH]) begin
          r.lo = `QUARTER_LO;
          r.hi = `USER_HI;
          r.vectors = 1'b1;
        end else begin
          r.lo = `USER_LO;
          r.hi = `FIFTH_HI;
          r.vectors = 1'b0;
        end
      end
      2'b10: begin
        r.lo = {a[15:`ROW8_LSB], 9'h000};
        r.hi = {a[15:`ROW8_LSB], 9'h1FF};
        r.vectors = 1'b0;
      end
      2'b11: begin
        r.lo = {a[15:`ROW1_LSB], 6'h00};
        r.hi = {a[15:`ROW1_LSB], 6'h3F};
        r.vectors = 1'b0;
      end
    endcase
    decode_range = r;
  endfunction : decode_range

  // lowest address locked by the protect byte; bit 3 guards the upper part,
  // the low bits are redundant and lock everything from the array base
  function automatic logic range_protected(input range_type r, input logic [7:0] p);
    logic [15:0] top;
    logic hit;
    top = r.vectors ? `VEC_HI : r.hi;
    hit = 1'b0;
    if (|p[`PROT_LOW_MSB:0]) begin
      hit = top >= `USER_LO;
    end else if (p[`PROT_UPPER_BIT]) begin
      hit = top >= `QUARTER_LO;
    end
    range_protected = hit;
  endfunction : range_protected

  function automatic logic [1:0] div_last(input logic [1:0] sel);
    logic [1:0] v;
    unique case (sel)
      2'b00: v = `PUMP_DIV1_LAST;
      2'b01: v = `PUMP_DIV2_LAST;
      2'b10: v = `PUMP_DIV2_LAST;
      2'b11: v = `PUMP_DIV4_LAST;
    endcase
    div_last = v;
  endfunction : div_last

  always_comb begin
    logic req;
    logic take;
    ctrl_type wd;
    ctrl_type cur;
    range_type rng;
    req = 1'b0;
    take = 1'b0;
    wd = '0;
    cur = '0;
    rng = '0;
    st_nxt = st_r;
    req = avs_read_i || avs_write_i;
    // answer one cycle after the request is seen; master samples it next edge
    take = req && !st_r.waitreq;
    st_nxt.waitreq = !(req && st_r.waitreq);
    cur = st_r.ctrl;
    wd = avs_writedata_i[7:0];

    // read data prepared while waitrequest is still high
    if (req && st_r.waitreq) begin
      st_nxt.rdata = '0;
      unique case (avs_address_i)
        `OFS_FLASH_CONTROL: st_nxt.rdata = {24'h00_0000, st_r.ctrl};
        `OFS_PROTECT_BYTE: st_nxt.rdata = {24'h00_0000, protect_byte_i};
        `OFS_LATCH_ADDR: st_nxt.rdata = {16'h0000, st_r.latched_addr};
        `OFS_ERASE_RANGE: st_nxt.rdata = {st_r.range.hi, st_r.range.lo};
        `OFS_STATUS: st_nxt.rdata = {26'h000_0000, st_r.range.vectors,
                                     st_r.protect_hit, st_r.seq, 2'b00};
        `OFS_SECOND_CONFIG: st_nxt.rdata = {31'h0000_0000, st_r.pump_regulator_enable};
        default: st_nxt.rdata = '0;
      endcase
    end

    if (take && avs_read_i && avs_address_i == `OFS_PROTECT_BYTE) begin
      st_nxt.protect = protect_byte_i;
      if (st_r.seq == SEQ_CONFIGURED) begin
        st_nxt.seq = SEQ_PROTECT_READ;
      end
    end

    if (take && avs_write_i) begin
      unique case (avs_address_i)
        `OFS_FLASH_CONTROL: begin
          st_nxt.ctrl.pump_div_sel1 = wd.pump_div_sel1;
          st_nxt.ctrl.pump_div_sel0 = wd.pump_div_sel0;
          st_nxt.ctrl.block_size_sel1 = wd.block_size_sel1;
          st_nxt.ctrl.block_size_sel0 = wd.block_size_sel0;
          // a select may rise only while the other is low and not rising too
          st_nxt.ctrl.erase_select = wd.erase_select &&
            (cur.erase_select || (!cur.program_select && !wd.program_select));
          st_nxt.ctrl.program_select = wd.program_select &&
            (cur.program_select || (!cur.erase_select && !wd.erase_select));
          // high voltage rises only after the full erase sequence, or in program mode once the protect byte is read
          st_nxt.ctrl.high_voltage_on = wd.high_voltage_on && (cur.high_voltage_on ||
            (st_nxt.ctrl.erase_select && st_r.seq == SEQ_ADDR_LATCHED) ||
            (st_nxt.ctrl.program_select && st_r.seq == SEQ_PROTECT_READ));
          st_nxt.ctrl.margin = wd.margin && !st_nxt.ctrl.high_voltage_on;
          if (!st_nxt.ctrl.erase_select && !st_nxt.ctrl.program_select) begin
            st_nxt.seq = SEQ_IDLE;
            st_nxt.ctrl.high_voltage_on = 1'b0;
          end else if (st_r.seq == SEQ_IDLE) begin
            st_nxt.seq = SEQ_CONFIGURED;
          end
        end
        `OFS_LATCH_ADDR: begin
          // in erase mode the write only latches the address; no array write
          if (cur.erase_select && !cur.high_voltage_on && is_flash(avs_writedata_i[15:0])
              && (st_r.seq == SEQ_PROTECT_READ || st_r.seq == SEQ_ADDR_LATCHED)) begin
            rng = decode_range(avs_writedata_i[15:0],
                               {cur.block_size_sel1, cur.block_size_sel0});
            st_nxt.latched_addr = avs_writedata_i[15:0];
            st_nxt.range = rng;
            st_nxt.protect_hit = range_protected(rng, st_r.protect);
            if (range_protected(rng, st_r.protect)) begin
              st_nxt.ctrl.erase_select = 1'b0;
              st_nxt.seq = SEQ_IDLE;
            end else begin
              st_nxt.seq = SEQ_ADDR_LATCHED;
            end
          end
        end
        `OFS_SECOND_CONFIG: begin
          st_nxt.pump_regulator_enable = avs_writedata_i[`CFG2_PUMP_REGULATOR_ENABLE];
        end
        default: begin
        end
      endcase
    end

    // pump clock enable tick from the bus clock
    if (st_r.div_cnt >= div_last({st_r.ctrl.pump_div_sel1, st_r.ctrl.pump_div_sel0})) begin
      st_nxt.div_cnt = 2'h0;
      st_nxt.pump_tick = 1'b1;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 2'h1;
      st_nxt.pump_tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_r <= '0;
      st_r.waitreq <= 1'b1;
      st_r.ctrl <= `FCR_RESET;
      st_r.pump_regulator_enable <= `CFG2_RESET;
      st_r.seq <= SEQ_IDLE;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata_o = st_r.rdata;
  assign avs_waitrequest_o = st_r.waitreq;
  // array erases the range only while both erase and high voltage stand
  assign high_voltage_on_o = st_r.ctrl.high_voltage_on;
  assign erase_select_o = st_r.ctrl.erase_select;
  assign program_select_o = st_r.ctrl.program_select;
  assign margin_o = st_r.ctrl.margin;
  assign pump_regulator_enable_o = st_r.pump_regulator_enable;
  assign pump_tick_o = st_r.pump_tick;
  assign erase_lo_o = st_r.range.lo;
  assign erase_hi_o = st_r.range.hi;
  assign erase_vectors_o = st_r.range.vectors;

endmodule : flash_block_erase_control

// file: verif/flash_erase_monitor.sv
`timescale 1ns/1ns
module flash_erase_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // bus
  input wire logic [4:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // array control
  input wire logic high_voltage_on_o,
  input wire logic erase_select_o,
  input wire logic program_select_o,
  input wire logic pump_tick_o,
  input wire logic [15:0] erase_lo_o,
  input wire logic [15:0] erase_hi_o,
  input wire logic erase_vectors_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic [2:0] gap_r;
  // the longest gap, at divide by 4, reaches three even across a divider switch, so four leaves a margin
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || pump_tick_o)
      gap_r <= 3'h0;
    else if (ce_i)
      gap_r <= gap_r + 3'h1;
  end
  sel_excl_a:
    assert property (!(erase_select_o && program_select_o)) else $error("both selects");
  erase_rise_a:
    assert property ($rose(erase_select_o) |-> $past(!program_select_o && avs_write_i
      && !avs_waitrequest_o)) else $error("erase set badly");
  hv_select_a:
    assert property (high_voltage_on_o |-> erase_select_o || program_select_o)
      else $error("hv without select");
  hv_by_write_a:
    assert property ($rose(high_voltage_on_o) |-> $past(avs_write_i && !avs_waitrequest_o
      && avs_address_i == 5'h00)) else $error("hv without write");
  pump_gap_a:
    assert property (gap_r <= 3'h4) else $error("pump tick missing");
  range_order_a:
    assert property (erase_lo_o <= erase_hi_o) else $error("range reversed");
  range_hold_a:
    assert property (high_voltage_on_o && $past(high_voltage_on_o) |-> $stable(erase_lo_o)
      && $stable(erase_hi_o)) else $error("range moved under hv");
  row_align_a:
    assert property (erase_hi_o - erase_lo_o == 16'h003F |-> erase_lo_o[5:0] == 6'h00)
      else $error("row misaligned");
  blk_align_a:
    assert property (erase_hi_o - erase_lo_o == 16'h01FF |-> erase_lo_o[8:0] == 9'h000)
      else $error("block misaligned");
  vec_top_a:
    assert property (erase_vectors_o |-> erase_hi_o == 16'hFDFF) else $error("vector top");
endmodule : flash_erase_monitor
bind flash_block_erase_control flash_erase_monitor flash_erase_monitor_i (.ref_clk_i,
  .srst_i, .ce_i, .avs_address_i, .avs_write_i, .avs_waitrequest_o, .high_voltage_on_o,
  .erase_select_o, .program_select_o, .pump_tick_o, .erase_lo_o, .erase_hi_o,
  .erase_vectors_o);

// file: verif/testbench.sv
`timescale 1ns/1ns
`include "flash_erase_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [7:0] protect_byte_i = 8'h00;
  logic [31:0] avs_readdata_o, rd;
  logic [15:0] erase_lo_o, erase_hi_o;
  logic avs_waitrequest_o, high_voltage_on_o, erase_select_o, program_select_o;
  logic margin_o, pump_regulator_enable_o, pump_tick_o, erase_vectors_o;
  int miscompares = 0;
  int cmp_count = 0;
  flash_block_erase_control flash_block_erase_control_i (.ref_clk_i, .srst_i, .ce_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .protect_byte_i, .high_voltage_on_o, .erase_select_o,
    .program_select_o, .margin_o, .pump_regulator_enable_o, .pump_tick_o, .erase_lo_o,
    .erase_hi_o, .erase_vectors_o);
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // request stands until waitrequest is seen low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // one more edge so that the effect of the access shows on the outputs
    @(posedge ref_clk_i);
  endtask : bus
  task automatic ctl(input logic [7:0] c);
    bus(1'b1, `OFS_FLASH_CONTROL, {24'h00_0000, c});
  endtask : ctl
  task automatic arm(input logic [1:0] b, input logic [15:0] a);
    ctl({2'h3, b, 4'h2});
    bus(1'b0, `OFS_PROTECT_BYTE, 32'h0000_0000);
    `CHK(rd[7:0], protect_byte_i)
    bus(1'b0, `OFS_STATUS, 32'h0000_0000);
    `CHK(rd[3:2], 2'h2)
    bus(1'b1, `OFS_LATCH_ADDR, {16'h0000, a});
  endtask : arm
  task automatic t_reset;
    `CHK(avs_waitrequest_o, 1'b1)
    bus(1'b0, `OFS_FLASH_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    bus(1'b1, `OFS_SECOND_CONFIG, 32'h0000_0001);
    `CHK(pump_regulator_enable_o, 1'b1)
    bus(1'b0, 5'h18, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("reset test done");
  endtask : t_reset
  task automatic t_ranges;
    logic [1:0] b [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    logic [15:0] a [7] = '{16'hD123, 16'hD123, 16'hB123, 16'hFB10, 16'hFD10, 16'hBC60,
      16'hBC87};
    logic [15:0] lo [7] = '{16'hB000, 16'hC000, 16'hB000, 16'hFA00, 16'hFC00, 16'hBC40,
      16'hBC80};
    logic [15:0] hi [7] = '{16'hFDFF, 16'hFDFF, 16'hBFFF, 16'hFBFF, 16'hFDFF, 16'hBC7F,
      16'hBCBF};
    logic [6:0] v = 7'h03;
    for (int i = 0; i < 7; i++) begin
      arm(b[i], a[i]);
      `CHK({erase_hi_o, erase_lo_o}, {hi[i], lo[i]})
      `CHK(erase_vectors_o, v[i])
      bus(1'b0, `OFS_ERASE_RANGE, 32'h0000_0000);
      `CHK(rd, {hi[i], lo[i]})
      bus(1'b0, `OFS_LATCH_ADDR, 32'h0000_0000);
      `CHK(rd, {16'h0000, a[i]})
      // margin asked together with high voltage must not stick
      ctl({2'h3, b[i], 4'hE});
      `CHK({high_voltage_on_o, margin_o}, 2'b10)
      ctl({2'h3, b[i], 4'h2});
      `CHK(high_voltage_on_o, 1'b0)
      ctl(8'h00);
      `CHK(erase_select_o, 1'b0)
    end
    $display("range test done");
  endtask : t_ranges
  task automatic t_no_read;
    ctl(8'hC2);
    bus(1'b1, `OFS_LATCH_ADDR, 32'h0000_D123);
    ctl(8'hCA);
    `CHK(high_voltage_on_o, 1'b0)
    ctl(8'h00);
    $display("skipped read test done");
  endtask : t_no_read
  task automatic t_protect;
    protect_byte_i <= 8'h08;
    arm(2'h1, 16'hD123);
    `CHK(erase_select_o, 1'b0)
    ctl(8'hDA);
    `CHK(high_voltage_on_o, 1'b0)
    arm(2'h1, 16'hB123);
    `CHK({erase_select_o, erase_lo_o}, {1'b1, 16'hB000})
    ctl(8'h00);
    protect_byte_i <= 8'h01;
    arm(2'h3, 16'hBC60);
    `CHK(erase_select_o, 1'b0)
    ctl(8'h00);
    protect_byte_i <= 8'h00;
    $display("protect test done");
  endtask : t_protect
  task automatic t_interlock;
    ctl(8'h03);
    `CHK({program_select_o, erase_select_o}, 2'b00)
    ctl(8'h02);
    ctl(8'h03);
    `CHK({program_select_o, erase_select_o}, 2'b01)
    ctl(8'h00);
    ctl(8'h01);
    bus(1'b0, `OFS_PROTECT_BYTE, 32'h0000_0000);
    ctl(8'h09);
    `CHK({high_voltage_on_o, program_select_o}, 2'b11)
    ctl(8'h00);
    $display("interlock test done");
  endtask : t_interlock
  task automatic t_pump;
    int n;
    for (int k = 0; k < 4; k++) begin
      ctl({k[1:0], 6'h00});
      repeat (8) @(negedge ref_clk_i);
      n = 0;
      repeat (24) begin
        @(negedge ref_clk_i);
        n += int'(pump_tick_o === 1'b1);
      end
      `CHK(n, (k == 0) ? 24 : (k == 3) ? 6 : 12)
    end
    $display("pump test done");
  endtask : t_pump
  task automatic t_freeze;
    int n;
    n = 0;
    do @(posedge ref_clk_i); while (pump_tick_o !== 1'b1);
    // just after a div 4 pulse; with the enable low the tick must not come back
    ce_i <= 1'b0;
    repeat (8) begin
      @(posedge ref_clk_i);
      n += int'(pump_tick_o === 1'b1);
    end
    ce_i <= 1'b1;
    `CHK(n, 0)
    $display("freeze test done");
  endtask : t_freeze
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_ranges();
    t_no_read();
    t_protect();
    t_interlock();
    t_pump();
    t_freeze();
    conclude();
  end
endmodule : testbench
